// >>> core/crs_defines.svh
/*
  constants of the cpu register file, status and stack block:
  i/o and data space locations, status bit positions, pointer
  registers and reset values.
  assumes it is included by bare name after the package guard.
*/
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// data space layout
`define CRS_GPR_COUNT        32
`define CRS_GPR_LAST         16'h001f
`define CRS_IO_BASE          16'h0020
`define CRS_IO_LAST          16'h005f
// i/o space locations
`define CRS_IO_STACK_POINTER 6'h3d
`define CRS_IO_STATUS        6'h3f
// immediate instructions reach only the upper half
`define CRS_IMM_BASE_BIT     1'h1
// pointer pairs, low byte register
`define CRS_PTR_X_LOW        5'h1a
`define CRS_PTR_Y_LOW        5'h1c
`define CRS_PTR_Z_LOW        5'h1e
// status bit positions
`define CRS_ST_GIE           7
`define CRS_ST_TBIT          6
`define CRS_ST_HALF          5
`define CRS_ST_SIGN          4
`define CRS_ST_OVF           3
`define CRS_ST_NEG           2
`define CRS_ST_ZERO          1
`define CRS_ST_CARRY         0
// reset values
`define CRS_RST_STATUS       8'h00
`define CRS_RST_SP           8'h00
`define CRS_RST_GPR          8'h00
// interrupt sources
`define CRS_IRQ_COUNT        8

`endif

// >>> core/crs_pkg.sv
/*
  types of the cpu register file, status and stack block.
  assumes crs_defines.svh sits beside it.
*/
`include "crs_defines.svh"

package crs_pkg;

  typedef enum logic [2:0] {
    crs_am_none,
    crs_am_direct,
    crs_am_io,
    crs_am_disp,
    crs_am_indirect,
    crs_am_predec,
    crs_am_postinc
  } crs_addr_mode_t;

  typedef enum logic [1:0] {
    crs_ptr_x,
    crs_ptr_y,
    crs_ptr_z
  } crs_ptr_sel_t;

  typedef enum logic [2:0] {
    crs_sp_hold,
    crs_sp_push,
    crs_sp_pop,
    crs_sp_call,
    crs_sp_ret
  } crs_stack_op_t;

  typedef struct packed {
    logic       en;
    logic       imm;
    logic [4:0] addr;
    logic [7:0] data;
  } crs_reg_wr_t;

  typedef struct packed {
    logic [7:0] we;
    logic [7:0] val;
  } crs_flag_upd_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } crs_ds_req_t;

  typedef struct packed {
    crs_addr_mode_t mode;
    crs_ptr_sel_t   ptr;
    logic [5:0]     disp;
    logic [5:0]     io_field;
    logic [15:0]    direct;
  } crs_ea_req_t;

endpackage

// >>> core/crs_gpr_mem.sv
/*
  32 x 8 working register array with three registered read ports,
  one byte write port and one pointer pair write port.
  assumes addresses are already legal; reads see same-cycle writes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.svh"

module crs_gpr_mem (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // read ports
  input  wire logic [4:0]  rd_addr_a,
  input  wire logic [4:0]  rd_addr_b,
  input  wire logic [4:0]  rd_addr_c,
  output logic      [7:0]  rd_data_a,
  output logic      [7:0]  rd_data_b,
  output logic      [7:0]  rd_data_c,
  // byte write
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // pointer pair write
  input  wire logic        pw_en,
  input  wire logic [4:0]  pw_low,
  input  wire logic [15:0] pw_data,
  // live pointers
  output logic      [15:0] ptr_x,
  output logic      [15:0] ptr_y,
  output logic      [15:0] ptr_z
);

  logic [7:0] gpr      [`CRS_GPR_COUNT];
  logic [7:0] next_gpr [`CRS_GPR_COUNT];

  // byte write wins over a pointer update of the same register
  for (genvar i = 0; i < `CRS_GPR_COUNT; i++) begin : g_entry
    always_comb begin
      next_gpr[i] = gpr[i];
      if (pw_en && pw_low == 5'(i)) begin
        next_gpr[i] = pw_data[7:0];
      end
      if (pw_en && pw_low + 5'h01 == 5'(i)) begin
        next_gpr[i] = pw_data[15:8];
      end
      if (wr_en && wr_addr == 5'(i)) begin
        next_gpr[i] = wr_data;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        gpr[i] <= `CRS_RST_GPR;
      end else begin
        gpr[i] <= next_gpr[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_a <= 8'h00;
      rd_data_b <= 8'h00;
      rd_data_c <= 8'h00;
    end else begin
      rd_data_a <= next_gpr[rd_addr_a];
      rd_data_b <= next_gpr[rd_addr_b];
      rd_data_c <= next_gpr[rd_addr_c];
    end
  end

  assign ptr_x = {gpr[`CRS_PTR_X_LOW + 5'h01], gpr[`CRS_PTR_X_LOW]};
  assign ptr_y = {gpr[`CRS_PTR_Y_LOW + 5'h01], gpr[`CRS_PTR_Y_LOW]};
  assign ptr_z = {gpr[`CRS_PTR_Z_LOW + 5'h01], gpr[`CRS_PTR_Z_LOW]};

endmodule

`default_nettype wire

// >>> core/crs_core_state.sv
/*
  cpu core state: working registers, pointers, processor status,
  stack pointer, interrupt gating and effective address generation.
  assumes a decoder and alu on the same clock that present read
  addresses one cycle before they use the operands.
*/
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.svh"

// Summary of operation
// RQ1: thirty-two byte registers, also reachable at data addresses 0x00 to 0x1f
// RQ2: immediate instructions address only registers sixteen to thirty-one
// RQ3: register and single-register operations reach all thirty-two registers
// RQ4: registers 26 to 31 form three 16-bit pointers, low byte first
// RQ5: operands read, result computed and written back within one cycle; the reads are registered, so write-back is one cycle later
// RQ6: processor status sits at i/o location 0x3f with eight flags
// RQ7: global interrupt enable low blocks every interrupt
// RQ8: accepted interrupt clears enable; return, set and clear ops change it
// RQ9: bit six holds the copied bit for bit store and bit load
// RQ10: sign flag always equals negative xor overflow
// RQ11: half, overflow, negative, zero and carry sit at fixed bits
// RQ12: stack pointer is eight bits at i/o 0x3d, data address 0x5d
// RQ13: push takes one from stack pointer, call or interrupt takes two
// RQ14: pop adds one to stack pointer, returns add two
// RQ15: software loads the stack pointer above 0x60 before calls
// RQ16: among pending interrupts the lowest vector is served first
// RQ17: i/o direct addressing uses a six-bit field of the instruction
// RQ18: data direct addressing uses a 16-bit address from the second word
// RQ19: displacement mode adds six-bit offset to second or third pointer
// RQ20: plain indirect mode uses the pointer unchanged
// RQ21: pre-decrement lowers the pointer first and uses the new value
// RQ22: post-increment uses the old value then raises the pointer
// RQ23: status and stack pointer reads are live; writes act next cycle
module crs_core_state (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // operand reads
  input  wire logic [4:0]             rd_addr_a,
  input  wire logic                   rd_imm_a,
  input  wire logic [4:0]             source_register,
  output logic      [7:0]             operand_a,
  output logic      [7:0]             operand_b,
  // result write and flags
  input  wire crs_pkg::crs_reg_wr_t   alu_wr,
  input  wire crs_pkg::crs_flag_upd_t flag_upd,
  // bit copy
  input  wire logic                   bit_store_op,
  input  wire logic                   bit_load_op,
  input  wire logic [4:0]             bit_load_reg,
  input  wire logic [2:0]             bit_sel,
  // global interrupt control
  input  wire logic                   set_global_irq,
  input  wire logic                   clear_global_irq,
  input  wire logic                   return_from_interrupt,
  input  wire logic                   irq_accept,
  input  wire logic [7:0]             irq_pending,
  output logic                        irq_req,
  output logic      [2:0]             irq_index,
  // stack and status
  input  wire crs_pkg::crs_stack_op_t stack_op,
  output logic      [7:0]             stack_pointer,
  output logic      [7:0]             processor_status,
  // data space access
  input  wire crs_pkg::crs_ds_req_t   ds_req,
  output logic      [7:0]             ds_rdata,
  output logic                        ds_rvalid,
  output logic                        ds_hit,
  // effective address
  input  wire crs_pkg::crs_ea_req_t   ea_req,
  output logic      [15:0]            ea,
  output logic                        ea_valid
);

  logic [7:0]  status;
  logic [7:0]  next_status;
  logic [7:0]  sp;
  logic [7:0]  next_sp;
  logic [4:0]  mem_rd_a;
  logic [7:0]  mem_data_a;
  logic [7:0]  mem_data_b;
  logic [7:0]  mem_data_c;
  logic        mem_wr_en;
  logic [4:0]  mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        pw_en;
  logic [4:0]  pw_low;
  logic [15:0] pw_data;
  logic [15:0] ptr_x;
  logic [15:0] ptr_y;
  logic [15:0] ptr_z;
  logic [15:0] ptr_sel;
  logic [15:0] next_ea;
  logic        ds_is_gpr;
  logic        ds_is_status;
  logic        ds_is_sp;
  logic        ds_gpr_q;
  logic        ds_rd_q;
  logic        ds_hit_q;
  logic [7:0]  io_rdata_q;
  logic [5:0]  ds_io_off;
  logic [7:0]  bld_data;
  logic [2:0]  next_irq_index;

  // address decode of the data space request
  assign ds_io_off    = ds_req.addr[5:0] - 6'h20;
  assign ds_is_gpr    = ds_req.addr <= `CRS_GPR_LAST; // RQ1
  assign ds_is_status = ds_req.addr == `CRS_IO_BASE
                        + {10'h000, `CRS_IO_STATUS}; // RQ6
  assign ds_is_sp     = ds_req.addr == `CRS_IO_BASE
                        + {10'h000, `CRS_IO_STACK_POINTER}; // RQ12

  // immediate forms fold onto the upper sixteen registers
  assign mem_rd_a = rd_imm_a ? {`CRS_IMM_BASE_BIT, rd_addr_a[3:0]}
                             : rd_addr_a; // RQ2

  // bit load replaces one bit of the operand with the copied bit
  always_comb begin
    bld_data          = mem_data_a;
    bld_data[bit_sel] = status[`CRS_ST_TBIT]; // RQ9
  end

  // byte write port: data space store, then bit load, then alu result
  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = 5'h00;
    mem_wr_data = 8'h00;
    if (ds_req.wr && ds_is_gpr) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = ds_req.addr[4:0]; // RQ1
      mem_wr_data = ds_req.wdata;
    end else if (bit_load_op) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = bit_load_reg;
      mem_wr_data = bld_data; // RQ9
    end else if (alu_wr.en) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = alu_wr.imm ? {`CRS_IMM_BASE_BIT, alu_wr.addr[3:0]}
                               : alu_wr.addr; // RQ2 RQ3
      mem_wr_data = alu_wr.data; // RQ5
    end
  end

  crs_gpr_mem u_gpr (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .rd_addr_a (mem_rd_a),
    .rd_addr_b (source_register),
    .rd_addr_c (ds_req.addr[4:0]),
    .rd_data_a (mem_data_a),
    .rd_data_b (mem_data_b),
    .rd_data_c (mem_data_c),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .pw_en     (pw_en),
    .pw_low    (pw_low),
    .pw_data   (pw_data),
    .ptr_x     (ptr_x),
    .ptr_y     (ptr_y),
    .ptr_z     (ptr_z)
  );

  assign operand_a = mem_data_a; // RQ3 RQ5
  assign operand_b = mem_data_b; // RQ3 RQ5

  // pointer selection
  always_comb begin
    unique case (ea_req.ptr)
      crs_pkg::crs_ptr_x: begin
        ptr_sel = ptr_x; // RQ4
        pw_low  = `CRS_PTR_X_LOW;
      end
      crs_pkg::crs_ptr_y: begin
        ptr_sel = ptr_y; // RQ4
        pw_low  = `CRS_PTR_Y_LOW;
      end
      crs_pkg::crs_ptr_z: begin
        ptr_sel = ptr_z; // RQ4
        pw_low  = `CRS_PTR_Z_LOW;
      end
      default: begin
        ptr_sel = ptr_z;
        pw_low  = `CRS_PTR_Z_LOW;
      end
    endcase
  end

  // effective address and pointer update per addressing mode
  always_comb begin
    next_ea = 16'h0000;
    pw_en   = 1'b0;
    pw_data = ptr_sel;
    unique case (ea_req.mode)
      crs_pkg::crs_am_none: begin
        next_ea = 16'h0000;
      end
      crs_pkg::crs_am_direct: begin
        next_ea = ea_req.direct; // RQ18
      end
      crs_pkg::crs_am_io: begin
        next_ea = `CRS_IO_BASE + {10'h000, ea_req.io_field}; // RQ17
      end
      crs_pkg::crs_am_disp: begin
        next_ea = ptr_sel + {10'h000, ea_req.disp}; // RQ19
      end
      crs_pkg::crs_am_indirect: begin
        next_ea = ptr_sel; // RQ20
      end
      crs_pkg::crs_am_predec: begin
        next_ea = ptr_sel - 16'h0001; // RQ21
        pw_en   = 1'b1;
        pw_data = ptr_sel - 16'h0001; // RQ21
      end
      crs_pkg::crs_am_postinc: begin
        next_ea = ptr_sel; // RQ22
        pw_en   = 1'b1;
        pw_data = ptr_sel + 16'h0001; // RQ22
      end
      default: begin
        next_ea = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ea       <= 16'h0000;
      ea_valid <= 1'b0;
    end else begin
      ea       <= next_ea;
      ea_valid <= ea_req.mode != crs_pkg::crs_am_none;
    end
  end

  // processor status
  always_comb begin
    next_status = status;
    if (ds_req.wr && ds_is_status) begin
      next_status = ds_req.wdata; // RQ23
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (flag_upd.we[b]) begin
          next_status[b] = flag_upd.val[b]; // RQ11
        end
      end
      if (bit_store_op) begin
        next_status[`CRS_ST_TBIT] = mem_data_a[bit_sel]; // RQ9
      end
      if (set_global_irq || return_from_interrupt) begin
        next_status[`CRS_ST_GIE] = 1'b1; // RQ8
      end
      if (clear_global_irq || irq_accept) begin
        next_status[`CRS_ST_GIE] = 1'b0; // RQ8
      end
    end
    next_status[`CRS_ST_SIGN] = next_status[`CRS_ST_NEG]
                                ^ next_status[`CRS_ST_OVF]; // RQ10
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status <= `CRS_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  assign processor_status = status; // RQ6

  // stack pointer
  always_comb begin
    next_sp = sp;
    if (ds_req.wr && ds_is_sp) begin
      next_sp = ds_req.wdata; // RQ23
    end else if (irq_accept) begin
      next_sp = sp - 8'h02; // RQ13
    end else begin
      unique case (stack_op)
        crs_pkg::crs_sp_hold: next_sp = sp;
        crs_pkg::crs_sp_push: next_sp = sp - 8'h01; // RQ13
        crs_pkg::crs_sp_call: next_sp = sp - 8'h02; // RQ13
        crs_pkg::crs_sp_pop:  next_sp = sp + 8'h01; // RQ14
        crs_pkg::crs_sp_ret:  next_sp = sp + 8'h02; // RQ14
        default:              next_sp = sp;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sp <= `CRS_RST_SP;
    end else begin
      sp <= next_sp; // RQ12
    end
  end

  assign stack_pointer = sp; // RQ12

  // interrupt gating and fixed priority, lowest index first
  always_comb begin
    next_irq_index = 3'h0;
    for (int k = `CRS_IRQ_COUNT - 1; k >= 0; k--) begin
      if (irq_pending[k]) begin
        next_irq_index = 3'(k); // RQ16
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_req   <= 1'b0;
      irq_index <= 3'h0;
    end else begin
      irq_req   <= next_status[`CRS_ST_GIE] && !irq_accept
                   && (|irq_pending); // RQ7
      irq_index <= next_irq_index; // RQ16
    end
  end

  // data space reads: live values captured in the request cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ds_rd_q    <= 1'b0;
      ds_gpr_q   <= 1'b0;
      ds_hit_q   <= 1'b0;
      io_rdata_q <= 8'h00;
    end else begin
      ds_rd_q    <= ds_req.rd;
      ds_gpr_q   <= ds_is_gpr;
      ds_hit_q   <= ds_is_gpr || ds_is_status || ds_is_sp;
      io_rdata_q <= ds_is_status ? status
                  : (ds_is_sp ? sp : 8'h00); // RQ23
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ds_rdata  <= 8'h00;
      ds_rvalid <= 1'b0;
      ds_hit    <= 1'b0;
    end else begin
      ds_rdata  <= ds_gpr_q ? mem_data_c : io_rdata_q; // RQ1
      ds_rvalid <= ds_rd_q;
      ds_hit    <= ds_rd_q && ds_hit_q;
    end
  end

  // the i/o offset of the data space request is not used anywhere
  logic unused_io_off;
  assign unused_io_off = ^ds_io_off;

endmodule

`default_nettype wire

// >>> tb/crs_alu_model.sv
/*
  alu partner model: adds the two operands of the core state block
  and hands back the result write and the flag update.
  assumes operands arrive registered from the block.
*/
`timescale 1ns/1ns
`default_nettype none

module crs_alu_model (
  // request
  input  wire logic       go,
  input  wire logic       imm,
  input  wire logic [4:0] dest,
  // operands
  input  wire logic [7:0] operand_a,
  input  wire logic [7:0] operand_b,
  // result
  output crs_pkg::crs_reg_wr_t   alu_wr,
  output crs_pkg::crs_flag_upd_t flag_upd
);
  logic [8:0] sum;
  logic [4:0] low;
  logic       ovf;
  assign sum = {1'b0, operand_a} + {1'b0, operand_b};
  assign low = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
  assign ovf = (operand_a[7] == operand_b[7]) && (sum[7] != operand_a[7]);
  assign alu_wr = '{en: go, imm: imm, addr: dest, data: sum[7:0]};
  assign flag_upd = '{we: go ? 8'h3f : 8'h00,
                      val: {2'b00, low[4], 1'b0, ovf, sum[7],
                            sum[7:0] == 8'h00, sum[8]}};
endmodule

`default_nettype wire

// >>> tb/crs_core_state_chk.sv
/*
  checker of the core state block: status, stack, interrupt and
  address relations at the top ports.
  assumes it is bound to crs_core_state.
*/
`timescale 1ns/1ns
`default_nettype none

module crs_core_state_chk (
  input wire logic                   sys_clk,
  input wire logic                   srst,
  input wire crs_pkg::crs_flag_upd_t flag_upd,
  input wire logic                   set_global_irq,
  input wire logic                   clear_global_irq,
  input wire logic                   return_from_interrupt,
  input wire logic                   irq_accept,
  input wire logic [7:0]             irq_pending,
  input wire logic                   irq_req,
  input wire logic [2:0]             irq_index,
  input wire crs_pkg::crs_stack_op_t stack_op,
  input wire logic [7:0]             stack_pointer,
  input wire logic [7:0]             processor_status,
  input wire crs_pkg::crs_ds_req_t   ds_req,
  input wire logic [7:0]             ds_rdata,
  input wire logic                   ds_hit,
  input wire crs_pkg::crs_ea_req_t   ea_req,
  input wire logic [15:0]            ea,
  input wire logic                   ea_valid
);
  logic sw_st;
  logic sw_sp;
  assign sw_st = ds_req.wr && ds_req.addr == 16'h005f;
  assign sw_sp = ds_req.wr && ds_req.addr == 16'h005d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sign_flag_a: assert property (
    processor_status[4] == (processor_status[3] ^ processor_status[2]))
    else $error("sign flag not n xor v");
  sp_push_a: assert property (
    stack_op == crs_pkg::crs_sp_push && !irq_accept && !sw_sp
    |=> stack_pointer == $past(stack_pointer) - 8'h01)
    else $error("push step wrong");
  sp_call_a: assert property (
    (stack_op == crs_pkg::crs_sp_call || irq_accept) && !sw_sp
    |=> stack_pointer == $past(stack_pointer) - 8'h02)
    else $error("call step wrong");
  sp_ret_a: assert property (
    stack_op == crs_pkg::crs_sp_ret && !irq_accept && !sw_sp
    |=> stack_pointer == $past(stack_pointer) + 8'h02)
    else $error("return step wrong");
  gie_clear_a: assert property (
    irq_accept && !sw_st |=> !processor_status[7])
    else $error("enable kept after accept");
  gie_set_a: assert property (
    (set_global_irq || return_from_interrupt) && !clear_global_irq
    && !irq_accept && !sw_st |=> processor_status[7])
    else $error("enable not set");
  irq_gate_a: assert property (irq_req |-> processor_status[7])
    else $error("request while disabled");
  irq_prio_a: assert property (
    irq_req |-> ($past(irq_pending) & ((8'h02 << irq_index) - 8'h01))
    == (8'h01 << irq_index))
    else $error("not lowest pending source");
  flag_write_a: assert property (
    flag_upd.we[0] && !sw_st |=> processor_status[0] == $past(flag_upd.val[0]))
    else $error("carry update lost");
  status_read_a: assert property (
    ds_req.rd && ds_req.addr == 16'h005f
    |-> ##2 ds_hit && ds_rdata == $past(processor_status, 2))
    else $error("status read wrong");
  sp_read_a: assert property (
    ds_req.rd && ds_req.addr == 16'h005d
    |-> ##2 ds_hit && ds_rdata == $past(stack_pointer, 2))
    else $error("stack pointer read wrong");
  ea_io_a: assert property (
    ea_req.mode == crs_pkg::crs_am_io
    |=> ea_valid && ea == 16'h0020 + $past(ea_req.io_field))
    else $error("io address wrong");
  ea_direct_a: assert property (
    ea_req.mode == crs_pkg::crs_am_direct |=> ea == $past(ea_req.direct))
    else $error("direct address wrong");

  cover property (irq_accept);
  cover property (ds_hit);
  cover property (ea_req.mode == crs_pkg::crs_am_postinc);
endmodule

bind crs_core_state crs_core_state_chk u_chk (
  .sys_clk, .srst, .flag_upd, .set_global_irq, .clear_global_irq,
  .return_from_interrupt, .irq_accept, .irq_pending, .irq_req, .irq_index,
  .stack_op, .stack_pointer, .processor_status, .ds_req, .ds_rdata,
  .ds_hit, .ea_req, .ea, .ea_valid
);

`default_nettype wire

// >>> tb/tb_crs_core_state.sv
/*
  testbench of the core state block with the alu partner model.
  assumes package, design and partner are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_crs_core_state;
  logic                   sys_clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   rd_imm_a, bit_store_op, bit_load_op, go, imm;
  logic                   set_global_irq, clear_global_irq, irq_accept;
  logic                   return_from_interrupt, irq_req, ds_rvalid, ds_hit;
  logic                   ea_valid;
  logic [4:0]             rd_addr_a, source_register, bit_load_reg, dest;
  logic [2:0]             bit_sel, irq_index;
  logic [7:0]             operand_a, operand_b, irq_pending, ds_rdata;
  logic [7:0]             stack_pointer, processor_status;
  logic [15:0]            ea;
  crs_pkg::crs_reg_wr_t   alu_wr;
  crs_pkg::crs_flag_upd_t flag_upd;
  crs_pkg::crs_stack_op_t stack_op;
  crs_pkg::crs_ds_req_t   ds_req;
  crs_pkg::crs_ea_req_t   ea_req;
  int                     miscompares = 0;
  int                     checks_done = 0;
  int                     cycles = 0;
  logic [7:0]             sp_exp [4] = '{8'h7f, 8'h80, 8'h7e, 8'h80};

  crs_core_state dut (.sys_clk, .srst, .rd_addr_a, .rd_imm_a,
    .source_register, .operand_a, .operand_b, .alu_wr, .flag_upd,
    .bit_store_op, .bit_load_op, .bit_load_reg, .bit_sel, .set_global_irq,
    .clear_global_irq, .return_from_interrupt, .irq_accept, .irq_pending,
    .irq_req, .irq_index, .stack_op, .stack_pointer, .processor_status,
    .ds_req, .ds_rdata, .ds_rvalid, .ds_hit, .ea_req, .ea, .ea_valid);
  crs_alu_model u_alu (.go, .imm, .dest, .operand_a, .operand_b,
    .alu_wr, .flag_upd);

  always #2 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ds_wr(input logic [15:0] a, input logic [7:0] d);
    ds_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    step;
    ds_req = '0;
    step;
  endtask

  task automatic ds_rd(input logic [15:0] a, input logic [7:0] d,
                       input logic h);
    ds_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    step;
    ds_req = '0;
    step;
    chk("ds_rvalid", {15'h0, ds_rvalid}, 16'h1);
    chk("ds_hit", {15'h0, ds_hit}, {15'h0, h});
    chk("ds_rdata", {8'h00, ds_rdata}, {8'h00, d});
  endtask

  task automatic ea_chk(input crs_pkg::crs_addr_mode_t m,
                        input crs_pkg::crs_ptr_sel_t p,
                        input logic [5:0] d, io, input logic [15:0] e);
    ea_req = '{mode: m, ptr: p, disp: d, io_field: io, direct: 16'h1234};
    step;
    ea_req = '0;
    chk("ea_valid", {15'h0, ea_valid}, 16'h1);
    chk("ea", ea, e);
    step;
  endtask

  initial begin
    {rd_imm_a, bit_store_op, bit_load_op, go, imm, irq_accept} = '0;
    {set_global_irq, clear_global_irq, return_from_interrupt} = '0;
    {rd_addr_a, source_register, bit_load_reg, dest, bit_sel} = '0;
    irq_pending = '0;
    stack_op = crs_pkg::crs_sp_hold;
    ds_req = '0;
    ea_req = '0;
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    ds_rd(16'h005f, 8'h00, 1'b1);
    ds_rd(16'h005d, 8'h00, 1'b1);
    ds_rd(16'h0060, 8'h00, 1'b0);
    for (int i = 0; i < 32; i++) ds_wr(16'(i), 8'(i ^ 'h5a));
    for (int i = 0; i < 32; i++) begin
      rd_addr_a = 5'(i);
      source_register = 5'(31 - i);
      step;
      chk("operand_a", {8'h00, operand_a}, 16'(i ^ 'h5a));
      chk("operand_b", {8'h00, operand_b}, 16'((31 - i) ^ 'h5a));
    end
    ds_rd(16'h001f, 8'h45, 1'b1);
    rd_imm_a = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd_addr_a = 5'(i);
      step;
      chk("imm operand", {8'h00, operand_a}, 16'((16 + i) ^ 'h5a));
    end
    rd_imm_a = 1'b0;
    for (int k = 0; k < 2; k++) begin
      ds_wr(16'h0001, k ? 8'h88 : 8'h70);
      ds_wr(16'h0002, k ? 8'h88 : 8'h10);
      rd_addr_a = 5'h01;
      source_register = 5'h02;
      step;
      go = 1'b1;
      imm = k[0];
      dest = 5'h03;
      step;
      go = 1'b0;
      chk("alu flags", {8'h00, processor_status}, k ? 16'h39 : 16'h0c);
      ds_rd(k ? 16'h0013 : 16'h0003, k ? 8'h10 : 8'h80, 1'b1);
    end
    rd_addr_a = 5'h03;
    step;
    bit_sel = 3'h7;
    bit_store_op = 1'b1;
    step;
    bit_store_op = 1'b0;
    chk("copy bit", {8'h00, processor_status}, 16'h0079);
    bit_sel = 3'h0;
    bit_load_reg = 5'h04;
    bit_load_op = 1'b1;
    step;
    bit_load_op = 1'b0;
    ds_rd(16'h0004, 8'h81, 1'b1);
    ds_wr(16'h005d, 8'h80);
    irq_pending = 8'h0c;
    step;
    chk("irq gated", {15'h0, irq_req}, 16'h0);
    set_global_irq = 1'b1;
    step;
    set_global_irq = 1'b0;
    chk("irq_req", {15'h0, irq_req}, 16'h1);
    chk("irq_index", {13'h0, irq_index}, 16'h2);
    irq_accept = 1'b1;
    step;
    irq_accept = 1'b0;
    chk("accept status", {8'h00, processor_status}, 16'h0079);
    chk("accept sp", {8'h00, stack_pointer}, 16'h007e);
    return_from_interrupt = 1'b1;
    stack_op = crs_pkg::crs_sp_ret;
    step;
    return_from_interrupt = 1'b0;
    stack_op = crs_pkg::crs_sp_hold;
    chk("return status", {8'h00, processor_status}, 16'h00f9);
    chk("return sp", {8'h00, stack_pointer}, 16'h0080);
    clear_global_irq = 1'b1;
    step;
    clear_global_irq = 1'b0;
    chk("clear status", {8'h00, processor_status}, 16'h0079);
    for (int k = 0; k < 4; k++) begin
      stack_op = crs_pkg::crs_stack_op_t'(k + 1);
      step;
      chk("stack step", {8'h00, stack_pointer}, {8'h00, sp_exp[k]});
    end
    stack_op = crs_pkg::crs_sp_hold;
    ds_wr(16'h005f, 8'h1c);
    chk("status write", {8'h00, processor_status}, 16'h000c);
    ds_rd(16'h005f, 8'h0c, 1'b1);
    ds_wr(16'h001a, 8'h10);
    ds_wr(16'h001b, 8'h01);
    ds_wr(16'h001c, 8'h80);
    ds_wr(16'h001d, 8'h00);
    ds_wr(16'h001e, 8'hff);
    ds_wr(16'h001f, 8'h00);
    ea_chk(crs_pkg::crs_am_direct, crs_pkg::crs_ptr_x, 6'h00, 6'h00, 16'h1234);
    ea_chk(crs_pkg::crs_am_io, crs_pkg::crs_ptr_x, 6'h00, 6'h3f, 16'h005f);
    ea_chk(crs_pkg::crs_am_disp, crs_pkg::crs_ptr_y, 6'h3f, 6'h00, 16'h00bf);
    ea_chk(crs_pkg::crs_am_disp, crs_pkg::crs_ptr_z, 6'h01, 6'h00, 16'h0100);
    ea_chk(crs_pkg::crs_am_indirect, crs_pkg::crs_ptr_z, 6'h0, 6'h0, 16'h00ff);
    ea_chk(crs_pkg::crs_am_predec, crs_pkg::crs_ptr_x, 6'h0, 6'h0, 16'h010f);
    ea_chk(crs_pkg::crs_am_indirect, crs_pkg::crs_ptr_x, 6'h0, 6'h0, 16'h010f);
    ea_chk(crs_pkg::crs_am_postinc, crs_pkg::crs_ptr_z, 6'h0, 6'h0, 16'h00ff);
    ea_chk(crs_pkg::crs_am_indirect, crs_pkg::crs_ptr_z, 6'h0, 6'h0, 16'h0100);
    ds_rd(16'h001f, 8'h01, 1'b1);
    finish_test;
  end
endmodule

`default_nettype wire
